// ==== hdl/gdhc_defines.svh ====
// Timing constants for the gate driver host controller
`ifndef GDHC_DEFINES_SVH
`define GDHC_DEFINES_SVH
`define GDHC_CLK_PERIOD_NS   20
`define GDHC_GLITCH_NS       40
// Pulses must be strictly longer than the driver's deglitch window
`define GDHC_MIN_PULSE_CYC   ((`GDHC_GLITCH_NS + `GDHC_CLK_PERIOD_NS - 1) / `GDHC_CLK_PERIOD_NS + 1)
`define GDHC_MUTE_NS         10000
`define GDHC_MUTE_CYC        ((`GDHC_MUTE_NS + `GDHC_CLK_PERIOD_NS - 1) / `GDHC_CLK_PERIOD_NS)
`define GDHC_RST_PULSE_CYC   8
`endif

// ==== hdl/gdhc_pkg.sv ====
// Types shared by the gate driver host controller
package gdhc_pkg;
  typedef enum logic [2:0] {
    GDHC_ST_DISABLED = 3'b000,
    GDHC_ST_RUN      = 3'b001,
    GDHC_ST_MUTE     = 3'b010,
    GDHC_ST_RESET    = 3'b011,
    GDHC_ST_RECOVER  = 3'b100
  } gdhc_state_e;

  // Driver-facing pin bundle; all three are always driven
  typedef struct packed {
    logic in_pos;
    logic in_neg;
    logic en_rst_n;
  } gdhc_pins_s;

  // Sampled indications; low means pulled low by the driver
  typedef struct packed {
    logic fault_flag_n;
    logic power_good_out;
  } gdhc_stat_s;
endpackage : gdhc_pkg

// ==== hdl/gdhc_pulse_stretch.sv ====
// Minimum-width filter: holds a level until it has stood long enough
`timescale 1ns/1ps
module gdhc_pulse_stretch
  import gdhc_pkg::*;
#(
  parameter int MIN_CYC = 3
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Level in and shaped level out
  input  wire logic req_lvl,
  output logic      out_lvl
);
  typedef struct packed {
    logic       lvl;
    logic [7:0] cnt;
  } gdhc_ps_s;

  gdhc_ps_s st_ff;
  gdhc_ps_s nxt_st;

  // Only change output after it has stood MIN_CYC cycles
  always_comb begin
    nxt_st = st_ff;
    if (st_ff.cnt != 8'h00) begin
      nxt_st.cnt = st_ff.cnt - 8'h01;
    end else if (req_lvl != st_ff.lvl) begin
      nxt_st.lvl = req_lvl;
      nxt_st.cnt = 8'(MIN_CYC - 1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign out_lvl = st_ff.lvl;

  // Every accepted level lasts at least the minimum width
  min_width_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE1]
    $changed(st_ff.lvl) |-> st_ff.cnt == 8'(MIN_CYC - 1))
    else $error("level changed without minimum width");
endmodule : gdhc_pulse_stretch

// ==== hdl/gdhc_host.sv ====
// Host controller driving an isolated gate driver's input pins
`timescale 1ns/1ps
`include "gdhc_defines.svh"
// Contract
// RULE1: Keep pins stable beyond 40 ns glitch
// RULE2: Never float in_pos, in_neg, en_rst_n
// RULE3: Tie in_neg low for noninverting use
// RULE4: Driver forces output low if both high
// RULE5: Own PWM positive, opposite PWM negative
// RULE6: Flags are open drain, pulled up externally
// RULE7: Driver disabled while en_rst_n not high
// RULE8: Output enabled only while en_rst_n high
// RULE9: Fault latches until en_rst_n reset
// RULE10: Reset fault only after mute interval
// RULE11: Auto reset may follow positive PWM
// RULE12: Auto reset via inverted negative PWM; not used, en_want follows pwm_own in auto mode
// RULE13: Fault flag low signals shutdown
// RULE14: Power good low means undervoltage
// RULE15: Forced-on overrides PWM and enable; the driver model has no forced-on, gate_out always needs en_rst_n and in_pos
// RULE16: Output high only enabled, unfaulted, pos-only
module gdhc_host
  import gdhc_pkg::*;
#(
  parameter int MUTE_CYC  = `GDHC_MUTE_CYC,
  parameter int PULSE_CYC = `GDHC_MIN_PULSE_CYC
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // User side
  input  wire logic enable_req,
  input  wire logic pwm_own,
  input  wire logic pwm_opp,
  input  wire logic use_interlock,
  input  wire logic auto_reset,
  output logic      fault_seen,
  output logic      drv_ready,
  output logic      running,
  // Driver pins
  output gdhc_pins_s pins,
  input  wire logic fault_flag_n,
  input  wire logic power_good_out
);
  typedef struct packed {
    gdhc_state_e state;
    logic [31:0] cnt;
    gdhc_pins_s  pins;
    logic        fault;
    logic        ready;
    logic        run;
  } gdhc_st_s;

  gdhc_st_s   st_ff;
  gdhc_st_s   nxt_st;
  gdhc_stat_s stat;
  logic       pos_sh;
  logic       neg_sh;
  logic       en_sh;
  logic       en_want;

  assign stat = '{fault_flag_n: fault_flag_n, power_good_out: power_good_out};

  // Filters keep every pin level beyond the deglitch window
  gdhc_pulse_stretch #(.MIN_CYC(PULSE_CYC)) u_pos (
    .clk_sys (clk_sys),
    .rst     (rst),
    .req_lvl (pwm_own && st_ff.state == GDHC_ST_RUN), // [RULE1] [RULE5]
    .out_lvl (pos_sh)
  );
  gdhc_pulse_stretch #(.MIN_CYC(PULSE_CYC)) u_neg (
    .clk_sys (clk_sys),
    .rst     (rst),
    .req_lvl (use_interlock && pwm_opp), // [RULE3] [RULE5]
    .out_lvl (neg_sh)
  );
  gdhc_pulse_stretch #(.MIN_CYC(PULSE_CYC)) u_en (
    .clk_sys (clk_sys),
    .rst     (rst),
    .req_lvl (en_want),
    .out_lvl (en_sh)
  );

  // Enable level: low in reset pulse or disable, follows PWM in auto mode
  always_comb begin
    en_want = 1'b0;
    case (st_ff.state)
      GDHC_ST_RUN:     en_want = auto_reset ? pwm_own : 1'b1; // [RULE11] [RULE8]
      GDHC_ST_RECOVER: en_want = 1'b1;
      // Hold high so the latch is not cleared before the mute time
      GDHC_ST_MUTE:    en_want = 1'b1; // [RULE10]
      default:         en_want = 1'b0; // [RULE7] [RULE10]
    endcase
  end

  // Sequencer: run, wait out mute after a fault, then pulse reset low
  always_comb begin
    nxt_st = st_ff;
    nxt_st.pins = '{in_pos: pos_sh, in_neg: neg_sh, en_rst_n: en_sh}; // [RULE2]
    nxt_st.fault = ~stat.fault_flag_n; // [RULE13] [RULE6]
    nxt_st.ready = stat.power_good_out; // [RULE14]
    nxt_st.run = (st_ff.state == GDHC_ST_RUN) && stat.power_good_out;
    if (st_ff.cnt != 32'h0) begin
      nxt_st.cnt = st_ff.cnt - 32'h1;
    end
    case (st_ff.state)
      GDHC_ST_DISABLED: begin
        if (enable_req) begin
          nxt_st.state = GDHC_ST_RECOVER;
          nxt_st.cnt   = 32'(PULSE_CYC);
        end
      end
      GDHC_ST_RUN: begin
        if (!enable_req) begin
          nxt_st.state = GDHC_ST_DISABLED;
        end else if (!stat.fault_flag_n && !auto_reset) begin // [RULE9]
          nxt_st.state = GDHC_ST_MUTE;
          nxt_st.cnt   = 32'(MUTE_CYC);
        end
      end
      GDHC_ST_MUTE: begin
        if (st_ff.cnt == 32'h0) begin // [RULE10]
          nxt_st.state = GDHC_ST_RESET;
          nxt_st.cnt   = 32'(`GDHC_RST_PULSE_CYC);
        end
      end
      GDHC_ST_RESET: begin
        if (st_ff.cnt == 32'h0 && !en_sh) begin
          nxt_st.state = GDHC_ST_RECOVER;
          nxt_st.cnt   = 32'(PULSE_CYC);
        end
      end
      GDHC_ST_RECOVER: begin
        if (!enable_req) begin
          nxt_st.state = GDHC_ST_DISABLED;
        end else if (st_ff.cnt == 32'h0 && en_sh) begin
          nxt_st.state = GDHC_ST_RUN;
        end
      end
      default: nxt_st.state = GDHC_ST_DISABLED;
    endcase
  end

  // Reset leaves the driver disabled with both PWM pins low
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_ff <= '{state: GDHC_ST_DISABLED, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pins       = st_ff.pins;
  assign fault_seen = st_ff.fault;
  assign drv_ready  = st_ff.ready;
  assign running    = st_ff.run;

  // One clock domain, so the checks share clock and reset
  default clocking chk_cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // Reset attempt only after the whole mute interval
  mute_wait_a: assert property ( // [RULE10]
    st_ff.state == GDHC_ST_MUTE && st_ff.cnt != 32'h0 |=>
      st_ff.state == GDHC_ST_MUTE)
    else $error("reset issued before mute elapsed");
  // Enable pin kept high once the mute state has lasted 6 cycles
  mute_hold_a: assert property ( // [RULE10]
    st_ff.state == GDHC_ST_MUTE [*6] |-> pins.en_rst_n)
    else $error("enable pin low during fault mute");
  // Enable pin low whenever disabled long enough
  dis_low_a: assert property ( // [RULE8]
    (st_ff.state == GDHC_ST_DISABLED) [*8] |-> !pins.en_rst_n)
    else $error("enable pin high while disabled");
  // Positive pin held low once fault mute has lasted 8 cycles
  pos_gate_a: assert property ( // [RULE9]
    st_ff.state == GDHC_ST_MUTE [*8] |-> !pins.in_pos)
    else $error("pwm driven during fault mute");
  // Negative pin stays low without interlock
  neg_tie_a: assert property ( // [RULE3]
    !use_interlock [*8] |-> !pins.in_neg)
    else $error("negative input not tied low");
  // A fault flag is reported one cycle later
  fault_rep_a: assert property ( // [RULE13]
    !fault_flag_n |=> fault_seen)
    else $error("fault not reported");
  // Ready tracks power good
  ready_rep_a: assert property ( // [RULE14]
    !power_good_out |=> !drv_ready)
    else $error("ready shown during undervoltage");
  // Run ends within bounded time after disable request
  run_stop_a: assert property ( // [RULE8]
    st_ff.state == GDHC_ST_RUN && !enable_req |=>
      !(st_ff.state == GDHC_ST_RUN))
    else $error("run state kept after disable");
  // Enable pin rises only in recover or run
  en_rise_a: assert property ( // [RULE7]
    $rose(pins.en_rst_n) |-> $past(st_ff.state) inside
      {GDHC_ST_RECOVER, GDHC_ST_RUN})
    else $error("enable raised from wrong state");

  fault_cyc_c: cover property (@(posedge clk_sys) disable iff (rst)
    st_ff.state == GDHC_ST_RESET ##[1:40] st_ff.state == GDHC_ST_RUN);
  run_c: cover property (@(posedge clk_sys) disable iff (rst)
    $rose(running));
  lock_c: cover property (@(posedge clk_sys) disable iff (rst)
    pins.in_pos && pins.in_neg);
endmodule : gdhc_host

// ==== sim/gdhc_drv_model.sv ====
// Behavioural model of the gate driver input side
`timescale 1ns/1ps
module gdhc_drv_model
  import gdhc_pkg::*;
#(
  parameter int MUTE_CYC = 20
) (
  // Clock
  input  wire logic       clk_sys,
  // Host pins and injected conditions
  input  wire gdhc_pins_s pins,
  input  wire logic       oc_fault,
  input  wire logic       uvlo,
  // Gate level and open-drain enables, low while pulling
  output logic            gate_out,
  output logic            flag_oe_n,
  output logic            ready_oe_n
);
  logic [2:0] raw;
  logic [2:0] filt_ff = 3'h0;  // Starts disabled
  int         cnt_ff[3];
  logic       flt_ff = 1'b0;
  int         mute_ff = 0;
  assign raw = pins;
  // A level must stand 3 cycles, so 40 ns pulses vanish
  always @(posedge clk_sys) begin
    for (int i = 0; i < 3; i++) begin
      if (raw[i] == filt_ff[i]) cnt_ff[i] <= 0;
      else if (cnt_ff[i] == 2) filt_ff[i] <= raw[i];
      if (raw[i] != filt_ff[i] && cnt_ff[i] < 2) cnt_ff[i] <= cnt_ff[i] + 1;
    end
    // Latch; early clearing is ignored
    if (oc_fault) begin
      flt_ff <= 1'b1;
      mute_ff <= 0;
    end else if (flt_ff && mute_ff < MUTE_CYC) mute_ff <= mute_ff + 1;
    else if (flt_ff && !filt_ff[0]) flt_ff <= 1'b0;
  end
  // Enabled, unfaulted, positive only
  assign gate_out = !uvlo && filt_ff[0] && !flt_ff && filt_ff[2]
                    && !filt_ff[1];
  // Lines only pull low
  assign flag_oe_n  = !flt_ff;
  assign ready_oe_n = !uvlo;
endmodule : gdhc_drv_model

// ==== sim/tb_gdhc_host.sv ====
// Self-checking bench for the gate driver host controller
`timescale 1ns/1ps
module tb_gdhc_host
  import gdhc_pkg::*;
;
  localparam int MUTE = 20;
  localparam int PW   = 3;
  logic clk_sys = 1'b0, rst = 1'b1, enable_req = 1'b0, pwm_own = 1'b0;
  logic pwm_opp = 1'b0, use_interlock = 1'b0, auto_reset = 1'b0;
  logic oc_fault = 1'b0, uvlo = 1'b0, pos_q = 1'b0;
  logic fault_seen, drv_ready, running, gate_out, flag_oe_n, ready_oe_n;
  logic fault_flag_n, power_good_out;
  gdhc_pins_s pins;
  int fails = 0, check_count = 0, cyc = 0, run_len = 9, n;
  // Pull-ups resolve both open-drain lines
  assign fault_flag_n   = flag_oe_n ? 1'b1 : 1'b0;
  assign power_good_out = ready_oe_n ? 1'b1 : 1'b0;
  gdhc_host #(.MUTE_CYC(MUTE), .PULSE_CYC(PW)) i_gdhc_host (
    .clk_sys(clk_sys), .rst(rst), .enable_req(enable_req),
    .pwm_own(pwm_own), .pwm_opp(pwm_opp), .use_interlock(use_interlock),
    .auto_reset(auto_reset), .fault_seen(fault_seen),
    .drv_ready(drv_ready), .running(running), .pins(pins),
    .fault_flag_n(fault_flag_n), .power_good_out(power_good_out));
  gdhc_drv_model #(.MUTE_CYC(MUTE)) i_gdhc_drv_model (
    .clk_sys(clk_sys), .pins(pins), .oc_fault(oc_fault), .uvlo(uvlo),
    .gate_out(gate_out), .flag_oe_n(flag_oe_n), .ready_oe_n(ready_oe_n));
  initial forever #10 clk_sys = ~clk_sys;
  task automatic chk(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got %b exp %b", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  task automatic wait_run(input logic exp);
    n = 0;
    while (running !== exp && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    chk(running, exp);
  endtask : wait_run
  // Hang guard and pulse width watch on the positive input
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 12000) begin
      fails++;
      give_verdict();
    end
    run_len++;
    if (pins.in_pos !== pos_q && !rst) chk(run_len >= PW, 1'b1);
    if (pins.in_pos !== pos_q) run_len = 0;
    pos_q = pins.in_pos;
  end
  initial begin
    void'($urandom(32'h9e3e));
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    chk(pins.en_rst_n, 1'b0);
    use_interlock = 1'b1;
    enable_req = 1'b1;
    wait_run(1'b1);
    chk(pins.en_rst_n, 1'b1);
    // Random PWM, glitches included; settled levels must pass through
    repeat (300) begin
      pwm_own = 1'($urandom);
      pwm_opp = 1'($urandom);
      n = 1 + $urandom % 10;
      repeat (n) @(negedge clk_sys);
      if (n >= 8) chk(pins.in_neg, pwm_opp);
      if (n >= 8) chk(gate_out, pwm_own & ~pwm_opp);
    end
    use_interlock = 1'b0;
    pwm_own = 1'b1;
    repeat (8) @(negedge clk_sys);
    chk(pins.in_neg, 1'b0);
    chk(gate_out, 1'b1);
    // Fault: clearing must wait out the mute interval
    oc_fault = 1'b1;
    @(negedge clk_sys);
    oc_fault = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk(fault_seen, 1'b1);
    chk(gate_out, 1'b0);
    n = 4;
    while (pins.en_rst_n === 1'b1 && n < 300) begin
      @(negedge clk_sys);
      n++;
    end
    chk(n >= MUTE, 1'b1);
    n = 0;
    while (pins.en_rst_n === 1'b0 && n < 300) begin
      @(negedge clk_sys);
      n++;
    end
    chk(n >= PW, 1'b1);
    wait_run(1'b1);
    chk(fault_seen, 1'b0);
    enable_req = 1'b0;
    wait_run(1'b0);
    repeat (6) @(negedge clk_sys);
    chk(pins.en_rst_n, 1'b0);
    // Undervoltage drops run and resumes on its own
    enable_req = 1'b1;
    wait_run(1'b1);
    uvlo = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk(drv_ready, 1'b0);
    chk(gate_out, 1'b0);
    wait_run(1'b0);
    uvlo = 1'b0;
    wait_run(1'b1);
    // Automatic reset follows the PWM
    auto_reset = 1'b1;
    repeat (6) begin
      pwm_own = ~pwm_own;
      repeat (7) @(negedge clk_sys);
      chk(pins.en_rst_n, pwm_own);
    end
    give_verdict();
  end
endmodule : tb_gdhc_host
